// ===== design/branch_eval_pkg.sv
// Package for the conditional branch evaluator: types and constants
package branch_eval_pkg;

  localparam int          PC_W        = 16;
  localparam int          OFS_W       = 7;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [15:0] PC_STEP     = 16'h0001;
  localparam int          TAKEN_CYC   = 2;
  localparam int          FALL_CYC    = 1;
  // Status flag positions
  localparam int          FLAG_CARRY  = 0;
  localparam int          FLAG_ZERO   = 1;
  localparam int          FLAG_NEG    = 2;

  typedef enum logic [2:0] {
    jump_if_equal,
    jump_if_unequal,
    jump_if_carry_set,
    jump_if_carry_clear,
    jump_if_same_or_higher,
    jump_if_lower,
    jump_if_minus
  } jump_op_t;

  // One issued branch instruction
  typedef struct packed {
    jump_op_t           op;
    logic [OFS_W-1:0]   ofs;
  } jump_req_t;

  // Outcome reported once the instruction retires
  typedef struct packed {
    logic               taken;
    logic [1:0]         cycles;
    logic [PC_W-1:0]    pc;
  } jump_res_t;

endpackage : branch_eval_pkg

// ===== design/conditional_branch_eval.sv
// Conditional relative branch evaluator for the 8-bit core
//
// Operation
// - jump_if_equal taken when zero flag is one: pc gets pc plus k plus one.
// - jump_if_unequal taken when zero flag is zero: pc plus k plus one.
// - jump_if_carry_set and jump_if_lower taken when carry is one.
// - jump_if_carry_clear and jump_if_same_or_higher taken when carry zero.
// - jump_if_minus taken when negative flag is one.
// - No branch changes any status flag, taken or not.
// - Every branch here completes in one or two clock cycles.
`timescale 1ns/1ps
module conditional_branch_eval
  import branch_eval_pkg::*;
#(
  // Counter and offset widths; the packed carriers fix them
  parameter int PC_WIDTH  = PC_W,
  parameter int OFS_WIDTH = OFS_W
)
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // Instruction issue
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire branch_eval_pkg::jump_req_t req,
  // Status flags from the core
  input  wire logic [7:0]                 flags_in,
  output logic [7:0]                      flags_out,
  // Program counter and completion
  output logic [branch_eval_pkg::PC_W-1:0] pc,
  output logic                            done,
  output branch_eval_pkg::jump_res_t      res
);
  import branch_eval_pkg::*;

  typedef enum logic [0:0] {ST_IDLE, ST_TAKEN} state_t;

  // Control group: sequencing and the retire strobe
  state_t                state_q, state_d;
  logic                  done_q, done_d;
  // Counter group: program counter and the pending jump target
  logic [PC_WIDTH-1:0]   pc_q, pc_d;
  logic [PC_WIDTH-1:0]   target_q, target_d;
  // Result group: outcome of the last retired instruction
  jump_res_t             res_q, res_d;

  // Decoded view of the instruction offered this cycle
  logic                  accept;
  logic                  cond_met;
  logic                  take_jump;
  logic                  fall_through;

  // The carriers fix both widths, so any other value is refused here
  if (PC_WIDTH != PC_W)
  begin : g_pc_width_check
    $error("pc width must equal the carrier pc width");
  end
  if (OFS_WIDTH != OFS_W)
  begin : g_ofs_width_check
    $error("offset width must equal the carrier offset width");
  end
  // Sign extension needs at least one spare bit above the offset
  if (OFS_WIDTH >= PC_WIDTH)
  begin : g_ext_check
    $error("offset must be narrower than the program counter");
  end
  // The cycle count field of the result is two bits wide
  if (TAKEN_CYC > 3 || FALL_CYC > 3 || FALL_CYC < 1)
  begin : g_cycle_check
    $error("cycle counts must fit the two-bit cycles field");
  end

  function automatic logic cond_holds(input jump_op_t op,
                                      input logic [7:0] f);
    logic r;
    r = 1'b0;
    unique case (op)
      jump_if_equal:          r = f[FLAG_ZERO];
      jump_if_unequal:        r = !f[FLAG_ZERO];
      jump_if_carry_set,
      jump_if_lower:          r = f[FLAG_CARRY];
      jump_if_carry_clear,
      jump_if_same_or_higher: r = !f[FLAG_CARRY];
      jump_if_minus:          r = f[FLAG_NEG];
      default:                r = 1'b0;
    endcase
    return r;
  endfunction : cond_holds

  // Signed word displacement, sign-extended to the counter width
  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] p,
                                                 input logic [OFS_W-1:0] k);
    logic [PC_W-1:0] kx;
    kx = {{(PC_W-OFS_W){k[OFS_W-1]}}, k};
    return p + kx + PC_STEP;
  endfunction : rel_target

  // Address of the instruction that follows in sequence
  function automatic logic [PC_W-1:0] seq_next(input logic [PC_W-1:0] p);
    return p + PC_STEP;
  endfunction : seq_next

  // The block never writes the flags; they pass straight back
  assign flags_out = flags_in;

  // A new branch is only taken while idle; the taken cycle refuses it
  assign req_ready    = (state_q == ST_IDLE);
  assign accept       = req_valid && req_ready;
  assign cond_met     = cond_holds(req.op, flags_in);
  assign take_jump    = accept && cond_met;
  assign fall_through = accept && !cond_met;

  assign pc   = pc_q;
  assign done = done_q;
  assign res  = res_q;

  // Control group
  always_comb
  begin
    state_d = state_q;
    done_d  = 1'h0;
    unique case (state_q)
      ST_IDLE:
      begin
        if (take_jump)
        begin
          // Second cycle models the pipeline refill of a taken branch
          state_d = ST_TAKEN;
        end
        else if (fall_through)
        begin
          done_d = 1'h1;
        end
      end
      ST_TAKEN:
      begin
        done_d  = 1'h1;
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      done_q  <= 1'h0;
    end
    else
    begin
      state_q <= state_d;
      done_q  <= done_d;
    end
  end

  // Counter group: the target is taken from the pc at issue, so a
  // taken jump lands relative to its own address
  always_comb
  begin
    pc_d     = pc_q;
    target_d = target_q;
    if (take_jump)
    begin
      target_d = rel_target(pc_q, req.ofs);
    end
    else if (fall_through)
    begin
      pc_d = seq_next(pc_q);
    end
    if (state_q == ST_TAKEN)
    begin
      pc_d = target_q;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pc_q     <= PC_RESET;
      target_q <= PC_RESET;
    end
    else
    begin
      pc_q     <= pc_d;
      target_q <= target_d;
    end
  end

  // Result group: holds between retirements so the core may read it late
  always_comb
  begin
    res_d = res_q;
    if (fall_through)
    begin
      res_d.taken  = 1'h0;
      res_d.cycles = 2'(FALL_CYC);
      res_d.pc     = seq_next(pc_q);
    end
    else if (state_q == ST_TAKEN)
    begin
      res_d.taken  = 1'h1;
      res_d.cycles = 2'(TAKEN_CYC);
      res_d.pc     = target_q;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      res_q <= '0;
    end
    else
    begin
      res_q <= res_d;
    end
  end

endmodule : conditional_branch_eval

// ===== bench/conditional_branch_eval_props.sv
// Checker for the conditional branch evaluator
`timescale 1ns/1ps
module branch_eval_chk
  import branch_eval_pkg::*;
(
  input wire logic clk_sys, rst, req_valid, req_ready, done,
  input wire branch_eval_pkg::jump_req_t req,
  input wire logic [7:0] flags_in, flags_out,
  input wire logic [15:0] pc,
  input wire branch_eval_pkg::jump_res_t res
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic acc, tk;
  logic [15:0] sx;
  assign acc = req_valid && req_ready;
  assign sx = {{9{req.ofs[6]}}, req.ofs};
  assign tk = (req.op == jump_if_equal && flags_in[1])
    || (req.op == jump_if_unequal && !flags_in[1])
    || (req.op inside {jump_if_carry_set, jump_if_lower} && flags_in[0])
    || (req.op inside {jump_if_carry_clear, jump_if_same_or_higher}
        && !flags_in[0]) || (req.op == jump_if_minus && flags_in[2]);
  sequence s_take; !done ##1 done && res.taken && res.cycles == 2'h2;
  endsequence
  sequence s_fall; done && !res.taken && res.cycles == 2'h1; endsequence
  property p_take; acc && tk |=> s_take; endproperty
  property p_fall; acc && !tk |=> s_fall; endproperty
  property p_tpc; acc && tk |-> ##2 pc == $past(pc, 2) + $past(sx, 2)
    + 16'h0001; endproperty
  property p_fpc; acc && !tk |=> pc == $past(pc) + 16'h0001; endproperty
  property p_flags; flags_out == flags_in; endproperty
  property p_busy; acc && tk |=> !req_ready; endproperty
  property p_idle; done |-> req_ready; endproperty
  property p_hold; !done && !$past(rst) |-> $stable(pc); endproperty
  a_take:
    assert property (p_take) else $error("taken");
  a_fall: assert property (p_fall) else $error("fall");
  a_tpc: assert property (p_tpc) else $error("target");
  a_fpc: assert property (p_fpc) else $error("step");
  a_flags: assert property (p_flags) else $error("flags");
  a_busy: assert property (p_busy) else $error("busy");
  a_idle: assert property (p_idle) else $error("idle");
  a_hold: assert property (p_hold) else $error("hold");
endmodule : branch_eval_chk
bind conditional_branch_eval branch_eval_chk u_chk (.*);

// ===== bench/conditional_branch_eval_tb_top.sv
// Self-checking bench for the conditional branch evaluator
`timescale 1ns/1ps
module conditional_branch_eval_tb_top;
  import branch_eval_pkg::*;
  typedef struct {jump_op_t op; logic [6:0] k; logic t;} row_t;
  logic clk_sys, rst, req_valid, req_ready, done;
  jump_req_t req;
  logic [7:0] flags_in, flags_out;
  logic [15:0] pc, ep;
  jump_res_t res;
  int errors, cmp_count, cyc;
  // Taken column holds the outcome with all flags set
  row_t rows[7] = '{'{jump_if_equal, 7'h3f, 1'h1},
    '{jump_if_unequal, 7'h40, 1'h0}, '{jump_if_carry_set, 7'h7f, 1'h1},
    '{jump_if_carry_clear, 7'h01, 1'h0},
    '{jump_if_same_or_higher, 7'h00, 1'h0},
    '{jump_if_lower, 7'h40, 1'h1}, '{jump_if_minus, 7'h3f, 1'h1}};
  conditional_branch_eval dut (.clk_sys(clk_sys), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .flags_in(flags_in), .flags_out(flags_out), .pc(pc), .done(done),
    .res(res));
  initial
  begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  task report_and_stop();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 400)
    begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(logic ok, string m);
    cmp_count++;
    if (ok !== 1'h1)
    begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic issue(jump_op_t op, logic [6:0] k, logic [7:0] f, logic t);
    int n;
    req = '{op, k};
    flags_in = f;
    req_valid = 1'h1;
    @(negedge clk_sys) req_valid = 1'h0;
    for (n = 0; done !== 1'h1 && n < 4; n++)
      @(negedge clk_sys);
    ep = t ? ep + {{9{k[6]}}, k} + 16'h0001 : ep + 16'h0001;
    chk(res.taken === t, "taken");
    chk(n == int'(t), "latency");
    chk(pc === ep && res.pc === ep, "pc");
    chk(res.cycles === (t ? 2'h2 : 2'h1), "cycles");
    chk(flags_out === f, "flags");
    // Let an edge pass so the next request never re-raises valid at once
    @(negedge clk_sys);
  endtask : issue
  initial
  begin
    {rst, req_valid, req, flags_in, ep} = {1'h1, 35'h0};
    repeat (4) @(negedge clk_sys);
    rst = 1'h0;
    foreach (rows[i])
      for (int j = 0; j < 2; j++)
        issue(rows[i].op, rows[i].k, j ? 8'hff : 8'h00,
              j ? rows[i].t : !rows[i].t);
    $display("table test done");
    req = '{jump_if_minus, 7'h05};
    flags_in = 8'h04;
    req_valid = 1'h1;
    @(negedge clk_sys) {req_valid, rst} = 2'h1;
    @(negedge clk_sys);
    chk(pc === 16'h0 && done === 1'h0 && req_ready === 1'h1, "rst");
    rst = 1'h0;
    ep = 16'h0;
    issue(jump_if_unequal, 7'h02, 8'h00, 1'h1);
    $display("reset test done");
    report_and_stop();
  end
endmodule : conditional_branch_eval_tb_top
